// ==== aucint_event_cell.sv ====
`timescale 1ns/10ps
`default_nettype none

module aucint_event_cell (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Source and configuration
  input  wire logic       src_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       enable_i,
  input  wire logic       clear_i,
  // Sticky flag
  output logic            flag_o
);

  logic prev_r;
  logic prev_nxt;
  logic flag_r;
  logic flag_nxt;
  logic hit;

  // Edge or level detection and sticky flag update
  always_comb begin
    prev_nxt = src_i;
    unique case (mode_i)
      aucint_pkg::MODE_RISE:  hit = src_i & ~prev_r;
      aucint_pkg::MODE_FALL:  hit = ~src_i & prev_r;
      aucint_pkg::MODE_LEVEL: hit = src_i;
      default:                hit = 1'b0;              // Reserved code never fires
    endcase
    if (!enable_i) begin
      flag_nxt = 1'b0;
    end else if (hit) begin
      flag_nxt = 1'b1;
    end else if (clear_i) begin
      flag_nxt = 1'b0;
    end else begin
      flag_nxt = flag_r;
    end
  end

  // State registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      flag_r <= flag_nxt;
    end
  end

  // Masked flag reads zero even in the cycle before the stored bit clears
  assign flag_o = flag_r & enable_i;

  property p_rise_set;
    @(posedge clk_i) disable iff (rst_i)
    (enable_i && mode_i == aucint_pkg::MODE_RISE && src_i && !$past(src_i)) |=> flag_r;
  endproperty
  a_rise_set: assert property (p_rise_set) else $error("rising edge not latched");

  property p_fall_set;
    @(posedge clk_i) disable iff (rst_i)
    (enable_i && mode_i == aucint_pkg::MODE_FALL && !src_i && $past(src_i)) |=> flag_r;
  endproperty
  a_fall_set: assert property (p_fall_set) else $error("falling edge not latched");

  property p_level_stay;
    @(posedge clk_i) disable iff (rst_i)
    (enable_i && mode_i == aucint_pkg::MODE_LEVEL && src_i && clear_i) |=> flag_r;
  endproperty
  a_level_stay: assert property (p_level_stay) else $error("level flag lost on read");

  property p_clear;
    @(posedge clk_i) disable iff (rst_i)
    (clear_i && !src_i && !prev_r) |=> !flag_r;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared by read");

  property p_sticky;
    @(posedge clk_i) disable iff (rst_i)
    (flag_r && enable_i && !clear_i) |=> flag_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without read");

  property p_disabled;
    @(posedge clk_i) disable iff (rst_i)
    !enable_i |=> !flag_r;
  endproperty
  a_disabled: assert property (p_disabled) else $error("masked flag set");

  c_level_hold: cover property (@(posedge clk_i) disable iff (rst_i)
    mode_i == aucint_pkg::MODE_LEVEL && flag_r && clear_i ##1 flag_r);

endmodule : aucint_event_cell

`default_nettype wire

// ==== aucint_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module aucint_host_model (
  // Clock
  input  wire logic       clk_i,
  // Register port
  input  wire logic [7:0] rdata_i,
  output logic      [6:0] addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] wdata_o
);
  // Idle port at time zero
  initial begin
    addr_o  = 7'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 8'h00;
  end

  // One-cycle write strobe; idle lines show the inverse afterwards
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clk_i);
    wr_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask : wr_reg

  // One-cycle read strobe; data taken after the read edge
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge clk_i);
    rd_o   = 1'b0;
    addr_o = ~a;
    d      = rdata_i;
  endtask : rd_reg
endmodule : aucint_host_model
`default_nettype wire

// ==== aucint_pin.sv ====
`timescale 1ns/10ps
`default_nettype none

module aucint_pin (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Request and polarity
  input  wire logic pending_i,
  input  wire logic active_low_i,
  // Pin
  output logic      int_o
);

  logic pin_r;
  logic pin_nxt;

  // Polarity comes only from the separate output setting
  always_comb begin
    pin_nxt = pending_i ^ active_low_i;
  end

  // Registered pin drive
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign int_o = pin_r;

endmodule : aucint_pin

`default_nettype wire

// ==== aucint_pkg.sv ====
`default_nettype none

package aucint_pkg;

  // Register offsets on the control port
  localparam logic [6:0] STAT1_OFS  = 7'h07;
  localparam logic [6:0] STAT2_OFS  = 7'h08;
  localparam logic [6:0] EN1_OFS    = 7'h09;
  localparam logic [6:0] MODE1H_OFS = 7'h0a;
  localparam logic [6:0] MODE1L_OFS = 7'h0b;
  localparam logic [6:0] EN2_OFS    = 7'h0c;
  localparam logic [6:0] MODE2H_OFS = 7'h0d;
  localparam logic [6:0] MODE2L_OFS = 7'h0e;

  // Reset value of every register in the unit
  localparam logic [7:0] REG_RST = 8'h00;

  // Implemented bit positions per bank
  localparam logic [7:0] BANK1_VALID = 8'hc7;
  localparam logic [7:0] BANK2_VALID = 8'h0e;

  // Bank one bit positions
  localparam int TX_SLIP_BIT      = 7;
  localparam int OUTPORT_SLIP_BIT = 6;
  localparam int CS_STAGE_BIT     = 2;
  localparam int CS_OUTPUT_BIT    = 1;
  localparam int RX_FAULT_BIT     = 0;

  // Bank two bit positions
  localparam int UD_STAGE_BIT     = 3;
  localparam int UD_OUTPUT_BIT    = 2;
  localparam int SUBCODE_BIT      = 1;

  // Trigger mode codes, upper bit from the high register
  localparam logic [1:0] MODE_RISE  = 2'h0;
  localparam logic [1:0] MODE_FALL  = 2'h1;
  localparam logic [1:0] MODE_LEVEL = 2'h2;
  localparam logic [1:0] MODE_RSVD  = 2'h3;

  // Frames the host has to drain a subcode block
  localparam int SUBCODE_READ_FRAMES = 588;

endpackage : aucint_pkg

`default_nettype wire

// ==== aucint_unit.sv ====
`timescale 1ns/10ps
`default_nettype none

module aucint_unit (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Register access port
  input  wire logic [6:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Transmitter events
  input  wire logic       tx_slip_evt_i,
  input  wire logic       tx_block_start_i,
  input  wire logic       tx_block_start_is_input_i,
  // Serial output port events
  input  wire logic       outport_slip_evt_i,
  input  wire logic       outport_slave_i,
  // Channel-status buffer transfers
  input  wire logic       cs_stage_move_i,
  input  wire logic       cs_output_move_i,
  // Receiver fault summary
  input  wire logic       rx_fault_i,
  // User-data buffer transfers
  input  wire logic       ud_stage_move_i,
  input  wire logic       ud_output_move_i,
  input  wire logic       ud_block_mode_i,
  // Subcode decoder
  input  wire logic       subcode_ready_i,
  // Interrupt pin
  input  wire logic       int_active_low_i,
  output logic            int_o
);

  // Mask and mode registers
  logic [7:0] en1_r;
  logic [7:0] en1_nxt;
  logic [7:0] en2_r;
  logic [7:0] en2_nxt;
  logic [7:0] mode1h_r;
  logic [7:0] mode1h_nxt;
  logic [7:0] mode1l_r;
  logic [7:0] mode1l_nxt;
  logic [7:0] mode2h_r;
  logic [7:0] mode2h_nxt;
  logic [7:0] mode2l_r;
  logic [7:0] mode2l_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Source levels, flags and read strobes
  logic [7:0] src1;
  logic [7:0] src2;
  logic [7:0] stat1;
  logic [7:0] stat2;
  logic       clr1;
  logic       clr2;
  logic       pending;
  logic       tx_slip_flag;
  logic       outport_slip_flag;
  logic       cs_stage_move_flag;
  logic       cs_output_move_flag;
  logic       rx_fault_flag;
  logic       ud_stage_move_flag;
  logic       ud_output_move_flag;
  logic       subcode_ready_flag;

  // Bank one sources
  always_comb begin
    src1 = 8'h00;
    if (tx_block_start_is_input_i) begin
      src1[aucint_pkg::TX_SLIP_BIT] = tx_block_start_i;
    end else begin
      src1[aucint_pkg::TX_SLIP_BIT] = tx_slip_evt_i;
    end
    src1[aucint_pkg::OUTPORT_SLIP_BIT] = outport_slip_evt_i & outport_slave_i;
    src1[aucint_pkg::CS_STAGE_BIT]     = cs_stage_move_i;
    src1[aucint_pkg::CS_OUTPUT_BIT]    = cs_output_move_i;
    src1[aucint_pkg::RX_FAULT_BIT]     = rx_fault_i;
  end

  // Bank two sources
  always_comb begin
    src2 = 8'h00;
    src2[aucint_pkg::UD_STAGE_BIT]  = ud_stage_move_i & ud_block_mode_i;
    src2[aucint_pkg::UD_OUTPUT_BIT] = ud_output_move_i & ud_block_mode_i;
    src2[aucint_pkg::SUBCODE_BIT]   = subcode_ready_i;
  end

  // Read strobes that clear the status banks
  assign clr1 = reg_rd_i && (reg_addr_i == aucint_pkg::STAT1_OFS);
  assign clr2 = reg_rd_i && (reg_addr_i == aucint_pkg::STAT2_OFS);

  // One event cell per implemented bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      if (aucint_pkg::BANK1_VALID[gi]) begin : g_b1
        aucint_event_cell u_cell (
          .clk_i    (clk_i),
          .rst_i    (rst_i),
          .src_i    (src1[gi]),
          .mode_i   ({mode1h_r[gi], mode1l_r[gi]}),
          .enable_i (en1_r[gi]),
          .clear_i  (clr1),
          .flag_o   (stat1[gi])
        );
      end else begin : g_z1
        assign stat1[gi] = 1'b0;
      end
      if (aucint_pkg::BANK2_VALID[gi]) begin : g_b2
        aucint_event_cell u_cell (
          .clk_i    (clk_i),
          .rst_i    (rst_i),
          .src_i    (src2[gi]),
          .mode_i   ({mode2h_r[gi], mode2l_r[gi]}),
          .enable_i (en2_r[gi]),
          .clear_i  (clr2),
          .flag_o   (stat2[gi])
        );
      end else begin : g_z2
        assign stat2[gi] = 1'b0;
      end
    end
  endgenerate

  // Named views of the flags
  assign tx_slip_flag        = stat1[aucint_pkg::TX_SLIP_BIT];
  assign outport_slip_flag   = stat1[aucint_pkg::OUTPORT_SLIP_BIT];
  assign cs_stage_move_flag  = stat1[aucint_pkg::CS_STAGE_BIT];
  assign cs_output_move_flag = stat1[aucint_pkg::CS_OUTPUT_BIT];
  assign rx_fault_flag       = stat1[aucint_pkg::RX_FAULT_BIT];
  assign ud_stage_move_flag  = stat2[aucint_pkg::UD_STAGE_BIT];
  assign ud_output_move_flag = stat2[aucint_pkg::UD_OUTPUT_BIT];
  assign subcode_ready_flag  = stat2[aucint_pkg::SUBCODE_BIT];

  // Register writes and read data capture
  always_comb begin
    en1_nxt    = en1_r;
    en2_nxt    = en2_r;
    mode1h_nxt = mode1h_r;
    mode1l_nxt = mode1l_r;
    mode2h_nxt = mode2h_r;
    mode2l_nxt = mode2l_r;
    rdata_nxt  = rdata_r;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        aucint_pkg::EN1_OFS:    en1_nxt    = reg_wdata_i & aucint_pkg::BANK1_VALID;
        aucint_pkg::EN2_OFS:    en2_nxt    = reg_wdata_i & aucint_pkg::BANK2_VALID;
        aucint_pkg::MODE1H_OFS: mode1h_nxt = reg_wdata_i & aucint_pkg::BANK1_VALID;
        aucint_pkg::MODE1L_OFS: mode1l_nxt = reg_wdata_i & aucint_pkg::BANK1_VALID;
        aucint_pkg::MODE2H_OFS: mode2h_nxt = reg_wdata_i & aucint_pkg::BANK2_VALID;
        aucint_pkg::MODE2L_OFS: mode2l_nxt = reg_wdata_i & aucint_pkg::BANK2_VALID;
        default:                ;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        aucint_pkg::STAT1_OFS:  rdata_nxt = stat1;
        aucint_pkg::STAT2_OFS:  rdata_nxt = stat2;
        aucint_pkg::EN1_OFS:    rdata_nxt = en1_r;
        aucint_pkg::EN2_OFS:    rdata_nxt = en2_r;
        aucint_pkg::MODE1H_OFS: rdata_nxt = mode1h_r;
        aucint_pkg::MODE1L_OFS: rdata_nxt = mode1l_r;
        aucint_pkg::MODE2H_OFS: rdata_nxt = mode2h_r;
        aucint_pkg::MODE2L_OFS: rdata_nxt = mode2l_r;
        default:                rdata_nxt = aucint_pkg::REG_RST; // Unmapped reads zero
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en1_r    <= aucint_pkg::REG_RST;
      en2_r    <= aucint_pkg::REG_RST;
      mode1h_r <= aucint_pkg::REG_RST;
      mode1l_r <= aucint_pkg::REG_RST;
      mode2h_r <= aucint_pkg::REG_RST;
      mode2l_r <= aucint_pkg::REG_RST;
      rdata_r  <= aucint_pkg::REG_RST;
    end else begin
      en1_r    <= en1_nxt;
      en2_r    <= en2_nxt;
      mode1h_r <= mode1h_nxt;
      mode1l_r <= mode1l_nxt;
      mode2h_r <= mode2h_nxt;
      mode2l_r <= mode2l_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

  // Any unmasked flag requests the pin
  assign pending = (|stat1) | (|stat2);

  // Pin driver, polarity set apart from the modes
  aucint_pin u_pin (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .pending_i    (pending),
    .active_low_i (int_active_low_i),
    .int_o        (int_o)
  );

  property p_reset_zero;
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (stat1 == 8'h00 && stat2 == 8'h00 && en1_r == 8'h00 && en2_r == 8'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("registers not zero after reset");

  property p_mode_reset;
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> ((mode1h_r | mode1l_r | mode2h_r | mode2l_r) == 8'h00);
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode registers not zero after reset");

  property p_masked_zero;
    @(posedge clk_i) disable iff (rst_i)
    ((stat1 & ~en1_r) == 8'h00) && ((stat2 & ~en2_r) == 8'h00);
  endproperty
  a_masked_zero: assert property (p_masked_zero) else $error("masked status bit set");

  property p_reserved_zero;
    @(posedge clk_i) disable iff (rst_i)
    ((stat1 | en1_r | mode1h_r | mode1l_r) & ~aucint_pkg::BANK1_VALID) == 8'h00 &&
    ((stat2 | en2_r | mode2h_r | mode2l_r) & ~aucint_pkg::BANK2_VALID) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit nonzero");

  property p_read_stat1;
    @(posedge clk_i) disable iff (rst_i)
    clr1 |=> (reg_rdata_o == $past(stat1));
  endproperty
  a_read_stat1: assert property (p_read_stat1) else $error("status read data wrong");

  property p_mask_write;
    @(posedge clk_i) disable iff (rst_i)
    (reg_wr_i && reg_addr_i == aucint_pkg::EN1_OFS) |=>
      (en1_r == ($past(reg_wdata_i) & aucint_pkg::BANK1_VALID));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write not applied");

  property p_int_pin;
    @(posedge clk_i) disable iff (rst_i)
    pending |=> (int_o != $past(int_active_low_i));
  endproperty
  a_int_pin: assert property (p_int_pin) else $error("pin not active with pending flag");

  property p_int_idle;
    @(posedge clk_i) disable iff (rst_i)
    !pending |=> (int_o == $past(int_active_low_i));
  endproperty
  a_int_idle: assert property (p_int_idle) else $error("pin active without flag");

  property p_tx_block;
    @(posedge clk_i) disable iff (rst_i)
    (tx_block_start_is_input_i && tx_block_start_i && !$past(tx_block_start_i) &&
     en1_r[aucint_pkg::TX_SLIP_BIT] && !mode1h_r[aucint_pkg::TX_SLIP_BIT] &&
     !mode1l_r[aucint_pkg::TX_SLIP_BIT] && !reg_wr_i) |=> tx_slip_flag;
  endproperty
  a_tx_block: assert property (p_tx_block) else $error("block start did not set slip flag");

  property p_ud_gate;
    @(posedge clk_i) disable iff (rst_i)
    (!ud_block_mode_i && !ud_stage_move_flag && !mode2l_r[aucint_pkg::UD_STAGE_BIT] &&
     !reg_wr_i) |=> !ud_stage_move_flag;
  endproperty
  a_ud_gate: assert property (p_ud_gate) else $error("user flag set outside block mode");

  c_int_rise: cover property (@(posedge clk_i) disable iff (rst_i) $rose(pending));
  c_read_clear: cover property (@(posedge clk_i) disable iff (rst_i)
    clr1 && rx_fault_flag ##1 !rx_fault_flag);
  c_subcode: cover property (@(posedge clk_i) disable iff (rst_i) $rose(subcode_ready_flag));
  c_both_banks: cover property (@(posedge clk_i) disable iff (rst_i)
    cs_output_move_flag && ud_output_move_flag && outport_slip_flag);

endmodule : aucint_unit

`default_nettype wire

// ==== test_aucint_unit.sv ====
`timescale 1ns/10ps
`default_nettype none

module test_aucint_unit;
  logic       clk_i;
  logic       rst_i;
  logic [6:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] src1;
  logic [7:0] src2;
  logic       blk_start;
  logic       blk_in;
  logic       slave;
  logic       blk_mode;
  logic       act_low;
  logic       int_pin;
  logic [7:0] v;
  int         num_errors;
  int         num_checks;
  localparam logic [6:0] OFS [8] = '{aucint_pkg::STAT1_OFS, aucint_pkg::STAT2_OFS,
    aucint_pkg::EN1_OFS, aucint_pkg::MODE1H_OFS, aucint_pkg::MODE1L_OFS,
    aucint_pkg::EN2_OFS, aucint_pkg::MODE2H_OFS, aucint_pkg::MODE2L_OFS};

  // Unit under test
  aucint_unit aucint_unit_i (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .tx_slip_evt_i(src1[7]),
    .tx_block_start_i(blk_start), .tx_block_start_is_input_i(blk_in),
    .outport_slip_evt_i(src1[6]), .outport_slave_i(slave), .cs_stage_move_i(src1[2]),
    .cs_output_move_i(src1[1]), .rx_fault_i(src1[0]), .ud_stage_move_i(src2[3]),
    .ud_output_move_i(src2[2]), .ud_block_mode_i(blk_mode), .subcode_ready_i(src2[1]),
    .int_active_low_i(act_low), .int_o(int_pin)
  );

  // Host on the register port
  aucint_host_model aucint_host_model_i (
    .clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata)
  );

  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Byte compare
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk_byte

  // Pin activity compare, polarity removed
  task automatic chk_pin(input string n, input logic e);
    num_checks++;
    if ((int_pin ^ act_low) !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %b got %b", n, e, int_pin ^ act_low);
    end
  endtask : chk_pin

  // Read a register and compare
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input string n);
    aucint_host_model_i.rd_reg(a, v);
    chk_byte(n, e, v);
  endtask : rd_chk

  // Set one source off the falling edge
  task automatic drive(input int bk, input int b, input logic val);
    @(negedge clk_i);
    if (bk == 1) begin
      src1[b] = val;
    end else begin
      src2[b] = val;
    end
  endtask : drive

  // One-cycle pulse, then time for flag and pin to settle
  task automatic pulse(input int bk, input int b);
    drive(bk, b, 1'b1);
    drive(bk, b, 1'b0);
    repeat (3) @(negedge clk_i);
  endtask : pulse

  // Rising-edge event end to end
  task automatic run_edge(input int bk, input int b);
    pulse(bk, b);
    chk_pin("pin after event", 1'b1);
    rd_chk(OFS[bk-1], 8'h01 << b, "event flag");
    rd_chk(OFS[bk-1], 8'h00, "flag after read");
    chk_pin("pin after read", 1'b0);
  endtask : run_edge

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    $display("CHECK FAILED run length exp done got hang");
    tally_and_finish();
  end

  // Main sequence
  initial begin
    rst_i = 1'b1;
    src1 = 8'h00;
    src2 = 8'h00;
    blk_start = 1'b0;
    blk_in = 1'b0;
    slave = 1'b1;
    blk_mode = 1'b1;
    act_low = 1'b0;
    num_errors = 0;
    num_checks = 0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 8; i++) rd_chk(OFS[i], aucint_pkg::REG_RST, "reset value");
    rd_chk(7'h05, 8'h00, "unmapped read");
    // Writable bits only, at the status bit positions
    for (int i = 2; i < 8; i++) begin
      aucint_host_model_i.wr_reg(OFS[i], 8'hff);
      rd_chk(OFS[i], (i < 5) ? 8'hc7 : 8'h0e, "write back");
    end
    aucint_host_model_i.wr_reg(OFS[0], 8'hff);
    rd_chk(OFS[0], 8'h00, "status write");
    for (int i = 3; i < 8; i++) if (i != 5) aucint_host_model_i.wr_reg(OFS[i], 8'h00);
    // Every source in rising mode
    for (int b = 0; b < 8; b++) if (aucint_pkg::BANK1_VALID[b]) run_edge(1, b);
    for (int b = 0; b < 8; b++) if (aucint_pkg::BANK2_VALID[b]) run_edge(2, b);
    // Masked source leaves no trace
    aucint_host_model_i.wr_reg(OFS[2], 8'h00);
    pulse(1, 7);
    chk_pin("pin masked", 1'b0);
    rd_chk(OFS[0], 8'h00, "masked flag");
    aucint_host_model_i.wr_reg(OFS[2], 8'hff);
    // Falling mode fires on removal only
    aucint_host_model_i.wr_reg(OFS[4], 8'hff);
    drive(1, 6, 1'b1);
    repeat (3) @(negedge clk_i);
    rd_chk(OFS[0], 8'h00, "fall on rise");
    drive(1, 6, 1'b0);
    repeat (3) @(negedge clk_i);
    rd_chk(OFS[0], 8'h40, "fall on removal");
    // Level mode survives reads while live
    aucint_host_model_i.wr_reg(OFS[4], 8'h00);
    aucint_host_model_i.wr_reg(OFS[3], 8'hff);
    drive(1, 0, 1'b1);
    repeat (3) @(negedge clk_i);
    rd_chk(OFS[0], 8'h01, "level live");
    rd_chk(OFS[0], 8'h01, "level after read");
    chk_pin("pin level", 1'b1);
    drive(1, 0, 1'b0);
    repeat (3) @(negedge clk_i);
    rd_chk(OFS[0], 8'h01, "level sticky");
    rd_chk(OFS[0], 8'h00, "level cleared");
    // Reserved code never fires
    aucint_host_model_i.wr_reg(OFS[4], 8'hff);
    pulse(1, 0);
    rd_chk(OFS[0], 8'h00, "reserved mode");
    aucint_host_model_i.wr_reg(OFS[3], 8'h00);
    aucint_host_model_i.wr_reg(OFS[4], 8'h00);
    // Block-start input replaces slip source
    blk_in = 1'b1;
    pulse(1, 7);
    rd_chk(OFS[0], 8'h00, "slip ignored");
    @(negedge clk_i);
    blk_start = 1'b1;
    @(negedge clk_i);
    blk_start = 1'b0;
    repeat (3) @(negedge clk_i);
    rd_chk(OFS[0], 8'h80, "block start");
    blk_in = 1'b0;
    // Port master and non-block mode gate their sources
    slave = 1'b0;
    pulse(1, 6);
    rd_chk(OFS[0], 8'h00, "port master");
    blk_mode = 1'b0;
    pulse(2, 3);
    rd_chk(OFS[1], 8'h00, "not block mode");
    blk_mode = 1'b1;
    // Active-low pin
    act_low = 1'b1;
    repeat (3) @(negedge clk_i);
    chk_pin("pin low idle", 1'b0);
    pulse(2, 1);
    chk_pin("pin low event", 1'b1);
    rd_chk(OFS[1], 8'h02, "subcode flag");
    // Reset in mid-run
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    rd_chk(OFS[2], 8'h00, "enable after reset");
    rd_chk(OFS[5], 8'h00, "enable two after reset");
    chk_pin("pin after reset", 1'b0);
    tally_and_finish();
  end
endmodule : test_aucint_unit
`default_nettype wire
